// ---- pkg/rscre_consts.svh ----
// constants for the return stack, call and reset execution block
// Function
// - push writes program counter plus two as new stack top
// - push moves previous top one level deeper, still retrievable
// - relative call decoded from prefix 11011 with 11-bit signed word offset
// - relative call pushes return address program counter plus two first
// - relative call then adds twice the offset to incremented counter
// - call target is call address plus two plus twice offset
// - relative call takes two cycles; second cycle discards fetched word
// - reset instruction clears stack depth and flags and loads the reset pc target; stack entries keep their values
// - pop discards top so previously pushed entry becomes top
`ifndef RSCRE_CONSTS_SVH
`define RSCRE_CONSTS_SVH
`define RSCRE_OP_PUSH 16'h0005
`define RSCRE_OP_POP 16'h0006
`define RSCRE_OP_RESET 16'h00FF
`define RSCRE_CALL_PFX 5'h1B
`define RSCRE_PFX_MSB 15
`define RSCRE_PFX_LSB 11
`define RSCRE_OFS_MSB 10
`define RSCRE_PC_STEP 21'h000002
`define RSCRE_PC_RST 21'h000000
`define RSCRE_FLAGS_RST 5'h00
`endif

// ---- pkg/rscre_pkg.sv ----
// types for the return stack, call and reset execution block
package rscre_pkg;
    typedef enum logic [1:0] {RSCRE_EXEC, RSCRE_FLUSH} rscre_state_e;
    typedef enum logic [2:0] {RSCRE_I_OTHER, RSCRE_I_PUSH, RSCRE_I_POP, RSCRE_I_CALL, RSCRE_I_RESET} rscre_instr_e;
endpackage : rscre_pkg

// ---- pkg/rscre_stack_if.sv ----
// push/pop request carrier between executor and return stack
`timescale 1ns/100ps
interface rscre_stack_if #(parameter int AW = 21);
    logic push;
    logic pop;
    logic clear;
    logic [AW-1:0] push_data;
    logic [AW-1:0] top;
    modport exec (output push, output pop, output clear, output push_data, input top);
    modport stack (input push, input pop, input clear, input push_data, output top);
endinterface : rscre_stack_if

// ---- hw/rscre_stack.sv ----
// hardware return stack
`timescale 1ns/100ps
`include "rscre_consts.svh"
module rscre_stack #(
    parameter int AW = 21,
    parameter int DEPTH = 31
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request side
    rscre_stack_if.stack sif,
    // status
    output logic [4:0] depth_q
);
    logic [AW-1:0] mem_q [DEPTH];

    // shift array: push moves every entry one deeper, pop one shallower
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
        end
        else if (sif.push)
        begin
            mem_q[0] <= sif.push_data;
            for (int i = 1; i < DEPTH; i++)
                mem_q[i] <= mem_q[i-1];
        end
        else if (sif.pop)
        begin
            for (int i = 0; i < DEPTH-1; i++)
                mem_q[i] <= mem_q[i+1];
            mem_q[DEPTH-1] <= '0;
        end
    end

    // occupancy count, saturating
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            depth_q <= '0;
        else if (sif.clear)
            depth_q <= '0;
        else if (sif.push && depth_q != 5'(DEPTH))
            depth_q <= depth_q + 5'h01;
        else if (sif.pop && depth_q != 5'h00)
            depth_q <= depth_q - 5'h01;
    end

    assign sif.top = mem_q[0];

    pop_restore_a: assert property (@(posedge clk) disable iff (!rst_n)
        sif.pop && !sif.push |=> mem_q[0] == $past(mem_q[1]))
        else $error("pop did not expose older entry");
    push_deeper_a: assert property (@(posedge clk) disable iff (!rst_n)
        sif.push |=> mem_q[1] == $past(mem_q[0]) && mem_q[0] == $past(sif.push_data))
        else $error("push did not shift stack");
endmodule : rscre_stack

// ---- hw/rscre_exec.sv ----
// executor for push, pop, relative call and software reset
`timescale 1ns/100ps
`include "rscre_consts.svh"
module rscre_exec #(
    parameter int AW = 21,
    parameter int DEPTH = 31
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // instruction fetch
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [AW-1:0] fetch_pc,
    // program counter control
    output logic pc_load,
    output logic [AW-1:0] pc_target,
    output logic discard,
    // core state
    output logic soft_reset,
    output logic [4:0] flags,
    output logic [AW-1:0] return_stack_top,
    output logic [4:0] stack_depth
);
    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;

    // release reset through two flops
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic rscre_pkg::rscre_instr_e decode(input logic [15:0] w);
        if (w == `RSCRE_OP_PUSH)
            return rscre_pkg::RSCRE_I_PUSH;
        if (w == `RSCRE_OP_POP)
            return rscre_pkg::RSCRE_I_POP;
        if (w == `RSCRE_OP_RESET)
            return rscre_pkg::RSCRE_I_RESET;
        if (w[`RSCRE_PFX_MSB:`RSCRE_PFX_LSB] == `RSCRE_CALL_PFX)
            return rscre_pkg::RSCRE_I_CALL;
        return rscre_pkg::RSCRE_I_OTHER;
    endfunction : decode

    rscre_pkg::rscre_state_e state_q;
    rscre_pkg::rscre_instr_e op;
    logic act;
    logic [AW-1:0] ret_addr;
    logic [AW-1:0] offs2;

    assign act = instr_valid && state_q == rscre_pkg::RSCRE_EXEC;
    assign op = act ? decode(instr) : rscre_pkg::RSCRE_I_OTHER;
    assign ret_addr = AW'(fetch_pc + `RSCRE_PC_STEP);
    // sign-extended 11-bit offset doubled
    assign offs2 = AW'({{(AW-11){instr[`RSCRE_OFS_MSB]}}, instr[`RSCRE_OFS_MSB:0]}) << 1;

    // ----------------------------------------
    // return stack
    // ----------------------------------------
    rscre_stack_if #(.AW(AW)) sif ();

    assign sif.push = op == rscre_pkg::RSCRE_I_PUSH || op == rscre_pkg::RSCRE_I_CALL;
    assign sif.pop = op == rscre_pkg::RSCRE_I_POP;
    assign sif.clear = op == rscre_pkg::RSCRE_I_RESET;
    assign sif.push_data = ret_addr;

    rscre_stack #(.AW(AW), .DEPTH(DEPTH)) u_stack (
        .clk(mclk),
        .rst_n(rst_n),
        .sif(sif),
        .depth_q(stack_depth)
    );
    assign return_stack_top = sif.top;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    // call holds a second, empty cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= rscre_pkg::RSCRE_EXEC;
        else
        begin
            unique case (state_q)
                rscre_pkg::RSCRE_EXEC:
                    if (op == rscre_pkg::RSCRE_I_CALL)
                        state_q <= rscre_pkg::RSCRE_FLUSH;
                rscre_pkg::RSCRE_FLUSH:
                    state_q <= rscre_pkg::RSCRE_EXEC;
            endcase
        end
    end
    assign discard = state_q == rscre_pkg::RSCRE_FLUSH;

    // program counter redirect, registered
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_load <= 1'b0;
            pc_target <= `RSCRE_PC_RST;
        end
        else if (op == rscre_pkg::RSCRE_I_CALL)
        begin
            pc_load <= 1'b1;
            pc_target <= AW'(ret_addr + offs2);
        end
        else if (op == rscre_pkg::RSCRE_I_RESET)
        begin
            pc_load <= 1'b1;
            pc_target <= `RSCRE_PC_RST;
        end
        else
            pc_load <= 1'b0;
    end

    // software reset pulse and status flags
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_reset <= 1'b0;
            flags <= `RSCRE_FLAGS_RST;
        end
        else
        begin
            soft_reset <= op == rscre_pkg::RSCRE_I_RESET;
            if (op == rscre_pkg::RSCRE_I_RESET)
                flags <= `RSCRE_FLAGS_RST;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    push_top_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op == rscre_pkg::RSCRE_I_PUSH |=> return_stack_top == $past(fetch_pc) + `RSCRE_PC_STEP)
        else $error("push top wrong");
    call_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op == rscre_pkg::RSCRE_I_CALL |=> return_stack_top == $past(fetch_pc) + `RSCRE_PC_STEP && pc_load)
        else $error("call return address wrong");
    call_target_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op == rscre_pkg::RSCRE_I_CALL |=> pc_target == AW'($past(fetch_pc) + `RSCRE_PC_STEP
            + AW'({{(AW-11){$past(instr[10])}}, $past(instr[10:0])} << 1)))
        else $error("call target wrong");
    call_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
        act && instr[15:11] == `RSCRE_CALL_PFX |-> sif.push)
        else $error("call not decoded");
    call_offset_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op == rscre_pkg::RSCRE_I_CALL && instr[10] |=> pc_target != AW'($past(fetch_pc) + `RSCRE_PC_STEP))
        else $error("offset sign lost");
    call_flush_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op == rscre_pkg::RSCRE_I_CALL |=> discard ##1 !discard)
        else $error("call not two cycles");
    soft_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op == rscre_pkg::RSCRE_I_RESET |=> soft_reset && pc_target == `RSCRE_PC_RST && stack_depth == 5'h00)
        else $error("reset incomplete");
    flags_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sif.push |=> $stable(flags) && !discard || $past(op) == rscre_pkg::RSCRE_I_CALL)
        else $error("push changed flags");
endmodule : rscre_exec

// ---- verif/rscre_exec_tb.sv ----
// self-checking bench for the push, call and reset executor
`timescale 1ns/100ps
`include "rscre_consts.svh"
module rscre_exec_tb;
    logic mclk;
    logic rstn;
    logic instr_valid;
    logic [15:0] instr;
    logic [20:0] fetch_pc;
    logic pc_load;
    logic [20:0] pc_target;
    logic discard;
    logic soft_reset;
    logic [4:0] flags;
    logic [20:0] return_stack_top;
    logic [4:0] stack_depth;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [20:0] stk[$];
    logic [20:0] pc;
    logic [10:0] ofs;
    logic [15:0] w;

    rscre_exec DUT (.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr), .fetch_pc(fetch_pc),
        .pc_load(pc_load), .pc_target(pc_target), .discard(discard), .soft_reset(soft_reset), .flags(flags),
        .return_stack_top(return_stack_top), .stack_depth(stack_depth));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    // free-running core clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // cut a hung run short
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task close_out();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // compare an address or count
    task chk_v(input logic [20:0] got, input logic [20:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : chk_v

    // compare a pulse or level
    task chk_b(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : chk_b

    // expected jump address of a relative call
    function logic [20:0] tgt(input logic [20:0] p, input logic [10:0] n);
        return p + `RSCRE_PC_STEP + {{9{n[10]}}, n, 1'b0};
    endfunction : tgt

    // present one word; bb keeps it valid into the next cycle
    task go(input logic [15:0] i, input logic [20:0] p, input bit bb);
        @(posedge mclk);
        instr <= i;
        fetch_pc <= p;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr_valid <= bb;
        #1;
    endtask : go

    // model push: oldest entry falls off a full stack
    task push_m(input logic [20:0] v);
        stk.push_front(v);
        if (stk.size() > 31)
            void'(stk.pop_back());
    endtask : push_m

    task chk_stack(input string what);
        chk_v(21'(stack_depth), 21'(stk.size()), what);
        if (stk.size() > 0)
            chk_v(return_stack_top, stk[0], what);
    endtask : chk_stack

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        fetch_pc = 21'h000000;
        void'($urandom(44166));
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        chk_v(21'(stack_depth), 21'h000000, "depth after reset");
        // pushes past full depth, then pops down past empty
        for (int k = 0; k < 33; k++)
        begin
            pc = 21'($urandom) & 21'h1FFFFE;
            go(`RSCRE_OP_PUSH, pc, 1'b0);
            push_m(pc + `RSCRE_PC_STEP);
            chk_stack("push");
            chk_b(pc_load, 1'b0, "push load");
        end
        for (int k = 0; k < 32; k++)
        begin
            go(`RSCRE_OP_POP, pc, 1'b0);
            if (stk.size() > 0)
                void'(stk.pop_front());
            chk_stack("pop");
        end
        // relative calls: offset corners, then random; word held into the dropped cycle
        for (int k = 0; k < 12; k++)
        begin
            ofs = (k == 0) ? 11'h400 : (k == 1) ? 11'h3FF : (k == 2) ? 11'h000 : 11'($urandom);
            pc = 21'($urandom) & 21'h1FFFFE;
            w = {`RSCRE_CALL_PFX, ofs};
            go(w, pc, 1'b1);
            push_m(pc + `RSCRE_PC_STEP);
            chk_stack("call push");
            chk_b(pc_load, 1'b1, "call load");
            chk_v(pc_target, tgt(pc, ofs), "call target");
            chk_b(discard, 1'b1, "call discard");
            chk_v(21'(flags), 21'h000000, "call flags");
            @(posedge mclk);
            instr_valid <= 1'b0;
            #1;
            chk_b(discard, 1'b0, "discard end");
            chk_b(pc_load, 1'b0, "load pulse");
            chk_stack("dropped word");
        end
        // random unrelated words leave the stack alone
        for (int k = 0; k < 16; k++)
        begin
            w = 16'($urandom);
            if (w == `RSCRE_OP_PUSH || w == `RSCRE_OP_POP || w == `RSCRE_OP_RESET || w[15:11] == `RSCRE_CALL_PFX)
                w = 16'h0000;
            go(w, pc, 1'b0);
            chk_stack("other word");
            chk_b(pc_load, 1'b0, "other load");
        end
        // software reset, then a push straight after
        go(`RSCRE_OP_RESET, pc, 1'b0);
        stk.delete();
        chk_b(soft_reset, 1'b1, "soft reset");
        chk_b(pc_load, 1'b1, "reset load");
        chk_v(21'(stack_depth), 21'h000000, "reset depth");
        chk_v(pc_target, `RSCRE_PC_RST, "reset target");
        chk_v(21'(flags), 21'(`RSCRE_FLAGS_RST), "reset flags");
        @(posedge mclk);
        #1;
        chk_b(soft_reset, 1'b0, "reset pulse");
        go(`RSCRE_OP_PUSH, pc, 1'b0);
        push_m(pc + `RSCRE_PC_STEP);
        chk_stack("push after reset");
        // two pushes on consecutive edges: each completes in one cycle
        pc = 21'($urandom) & 21'h1FFFFE;
        @(posedge mclk);
        instr <= `RSCRE_OP_PUSH;
        fetch_pc <= pc;
        instr_valid <= 1'b1;
        push_m(pc + `RSCRE_PC_STEP);
        pc = 21'($urandom) & 21'h1FFFFE;
        @(posedge mclk);
        fetch_pc <= pc;
        push_m(pc + `RSCRE_PC_STEP);
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk_stack("back to back push");
        chk_b(pc_load, 1'b0, "back to back load");
        // a pop then exposes the entry pushed one edge earlier
        go(`RSCRE_OP_POP, pc, 1'b0);
        void'(stk.pop_front());
        chk_stack("pop to older");
        close_out();
    end
endmodule : rscre_exec_tb
